//--- core/sof_pkg.sv
// Constants shared by the serial output frame and mapper configuration block
package sof_pkg;

    // ---------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [5:0] IDX_FRAME_CLOCK = 6'h19;
    localparam logic [5:0] IDX_DRIVE = 6'h1A;
    localparam logic [5:0] IDX_MAPPER = 6'h1B;
    localparam logic [5:0] IDX_DELAY = 6'h1E;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int FC_SRC_BIT = 7;
    localparam int FC_DIV_BIT = 4;
    localparam int FC_STRETCH_BIT = 0;
    localparam int DRV_HALF_BIT = 6;
    localparam int MAP_EN_BIT = 7;
    localparam int MAP_WIDE_BIT = 6;
    localparam int MAP_RES_LSB = 3;
    localparam int DLY_WORD_LSB = 2;
    localparam int DLY_BCLK_LSB = 0;

    // Writable bits; the rest hold no state and read as zero
    localparam logic [7:0] FC_MASK = 8'h91;
    localparam logic [7:0] DRV_MASK = 8'h40;
    localparam logic [7:0] MAP_MASK = 8'hF8;
    localparam logic [7:0] DLY_MASK = 8'h0F;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] FC_RESET = 8'h00;
    localparam logic [7:0] DRV_RESET = 8'h00;
    localparam logic [7:0] MAP_RESET = 8'h08;
    localparam logic [7:0] DLY_RESET = 8'h00;

    // ---------------------------------------------------------------
    // Resolution codes and word widths
    // ---------------------------------------------------------------
    localparam logic [2:0] RES_18 = 3'h0;
    localparam logic [2:0] RES_16 = 3'h1;
    localparam logic [2:0] RES_14 = 3'h2;
    localparam int SAMPLE_W = 20;
    localparam int RES_W = 5;
    localparam logic [4:0] BITS_20 = 5'h14;
    localparam logic [4:0] BITS_18 = 5'h12;
    localparam logic [4:0] BITS_16 = 5'h10;
    localparam logic [4:0] BITS_14 = 5'h0E;
    localparam int FIFO_DEPTH = 8;

    // ---------------------------------------------------------------
    // Effective output word width
    // ---------------------------------------------------------------
    function automatic logic [4:0] res_bits(input logic wide, input logic map_en,
                                            input logic bypass, input logic [2:0] code);
        logic [4:0] bits;
        bits = BITS_16;
        if (wide)
            bits = BITS_20;
        else if (!bypass || map_en)
        begin
            case (code)
                RES_18: bits = BITS_18;
                RES_14: bits = BITS_14;
                default: bits = BITS_16;
            endcase
        end
        return bits;
    endfunction

    // Keep the top bits of a sample, clear the rest
    function automatic logic [19:0] map_word(input logic [19:0] smp, input logic [4:0] bits);
        logic [19:0] keep;
        keep = 20'hFFFFF << (5'h14 - bits);
        return smp & keep;
    endfunction

endpackage

//--- core/sof_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sof_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Fill side
    input wire logic [WIDTH-1:0] s_data,
    input wire logic s_valid,
    output logic s_ready,
    // Drain side
    output logic [WIDTH-1:0] m_data,
    output logic m_valid,
    input wire logic m_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic full;
    logic empty;
    wire push = s_valid && !full;
    wire pop = m_valid && m_ready;
    wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign s_ready = !full;
    assign m_valid = !empty;
    assign m_data = mem[rd_ptr];

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            full <= 1'b0;
            empty <= 1'b1;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            count <= next_count;
            full <= (next_count == (AW + 1)'(DEPTH));
            empty <= (next_count == '0);
        end
    end

    // Storage needs no reset; only read once written
    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem[wr_ptr] <= s_data;
    end
endmodule
`default_nettype wire

//--- core/sof_frame_gen.sv
// Frame clock generator: source select, divide and stretch
`timescale 1ns/1ps
`default_nettype none
module sof_frame_gen (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Configuration
    input wire logic src_ddc,
    input wire logic divide,
    input wire logic stretch,
    // Frame strobes from the core and the downconverter block
    input wire logic core_tick,
    input wire logic ddc_tick,
    // Frame clock level
    output logic frame_clock
);
    logic phase;
    wire sel_tick = src_ddc ? ddc_tick : core_tick;
    // Divide and stretch both hold each level over two strobes (A and B)
    wire two_step = divide || stretch;
    wire flip = sel_tick && (!two_step || phase);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase <= 1'b0;
            frame_clock <= 1'b0;
        end
        else
        begin
            if (sel_tick)
                phase <= two_step ? !phase : 1'b0;
            if (flip)
                frame_clock <= !frame_clock;
        end
    end

    property p_src_core_ignores_ddc;
        @(posedge sys_clk) disable iff (!rst_b)
        (!src_ddc && ddc_tick && !core_tick) |=> $stable(frame_clock);
    endproperty
    a_src_core_ignores_ddc: assert property (p_src_core_ignores_ddc)
        else $error("frame clock moved on a strobe of the unselected source");

    property p_stretch_holds;
        @(posedge sys_clk) disable iff (!rst_b)
        (stretch && sel_tick && !phase) |=> $stable(frame_clock);
    endproperty
    a_stretch_holds: assert property (p_stretch_holds)
        else $error("stretched frame clock changed after channel A strobe");
endmodule
`default_nettype wire

//--- core/sof_serial_out_cfg.sv
// Serial output frame clock and bit mapper configuration with APB access
//
// Notes on behaviour
// - Frame bit 7 picks core or downconverter source.
// - Stretch bit 0 spans channel A and B.
// - Mapper enable changes resolution in bypass only.
// - Wide word bit 6 gives 20-bit words.
// - Resolution field 000/001/010 = 18/16/14, reset 001.
`timescale 1ns/1ps
`default_nettype none
module sof_serial_out_cfg (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Datapath mode and frame strobes
    input wire logic decim_bypass,
    input wire logic core_frame_tick,
    input wire logic ddc_frame_tick,
    // Sample stream in
    input wire logic [19:0] in_sample,
    input wire logic in_valid,
    output logic in_ready,
    // Mapped word stream out
    output logic [19:0] out_word,
    output logic [4:0] out_res,
    output logic out_valid,
    input wire logic out_ready,
    // Output pin controls
    output logic frame_clock,
    output logic half_drive_current,
    output logic [1:0] output_word_delay,
    output logic [1:0] bit_clock_delay
);

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [7:0] frame_clock_config;
    logic [7:0] output_drive_config;
    logic [7:0] output_mapper_config;
    logic [7:0] output_delay_config;

    // ---------------------------------------------------------------
    // APB decode
    // ---------------------------------------------------------------
    wire [5:0] idx = paddr[7:2];
    wire hit_fc = (idx == sof_pkg::IDX_FRAME_CLOCK);
    wire hit_drv = (idx == sof_pkg::IDX_DRIVE);
    wire hit_map = (idx == sof_pkg::IDX_MAPPER);
    wire hit_dly = (idx == sof_pkg::IDX_DELAY);
    wire hit_any = hit_fc || hit_drv || hit_map || hit_dly;
    wire setup = psel && !penable;
    // One wait-free answer: pready rises in the access cycle after setup
    wire access_done = psel && penable && pready;
    // Only byte lane 0 carries a register; other lanes are dropped
    wire wr_en = access_done && pwrite && hit_any && pstrb[0];
    wire [7:0] wbyte = pwdata[7:0];

    wire [7:0] rd_byte =
        hit_fc ? frame_clock_config :
        hit_drv ? output_drive_config :
        hit_map ? output_mapper_config :
        hit_dly ? output_delay_config : 8'h00;
    wire [31:0] next_prdata = {24'h000000, rd_byte};

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !hit_any;
            if (setup && !pwrite)
                prdata <= next_prdata;
        end
    end

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    // Reserved bits are masked off so stray writes leave no trace
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            frame_clock_config <= sof_pkg::FC_RESET;
            output_drive_config <= sof_pkg::DRV_RESET;
            output_mapper_config <= sof_pkg::MAP_RESET;
            output_delay_config <= sof_pkg::DLY_RESET;
        end
        else if (wr_en)
        begin
            if (hit_fc)
                frame_clock_config <= wbyte & sof_pkg::FC_MASK;
            if (hit_drv)
                output_drive_config <= wbyte & sof_pkg::DRV_MASK;
            if (hit_map)
                output_mapper_config <= wbyte & sof_pkg::MAP_MASK;
            if (hit_dly)
                output_delay_config <= wbyte & sof_pkg::DLY_MASK;
        end
    end

    // ---------------------------------------------------------------
    // Field extraction
    // ---------------------------------------------------------------
    wire frame_clock_source_select = frame_clock_config[sof_pkg::FC_SRC_BIT];
    wire frame_clock_divide = frame_clock_config[sof_pkg::FC_DIV_BIT];
    wire frame_clock_stretch = frame_clock_config[sof_pkg::FC_STRETCH_BIT];
    wire mapper_enable = output_mapper_config[sof_pkg::MAP_EN_BIT];
    wire wide_word_enable = output_mapper_config[sof_pkg::MAP_WIDE_BIT];
    wire [2:0] output_resolution_select = output_mapper_config[sof_pkg::MAP_RES_LSB +: 3];

    assign half_drive_current = output_drive_config[sof_pkg::DRV_HALF_BIT];
    assign output_word_delay = output_delay_config[sof_pkg::DLY_WORD_LSB +: 2];
    assign bit_clock_delay = output_delay_config[sof_pkg::DLY_BCLK_LSB +: 2];

    // ---------------------------------------------------------------
    // Frame clock
    // ---------------------------------------------------------------
    // Divide is applied as set; software picks it per lane/mode
    sof_frame_gen u_frame (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .src_ddc(frame_clock_source_select),
        .divide(frame_clock_divide),
        .stretch(frame_clock_stretch),
        .core_tick(core_frame_tick),
        .ddc_tick(ddc_frame_tick),
        .frame_clock(frame_clock)
    );

    // ---------------------------------------------------------------
    // Sample buffer
    // ---------------------------------------------------------------
    logic [19:0] fifo_data;
    logic fifo_valid;
    wire load = fifo_valid && (!out_valid || out_ready);

    sof_fifo #(
        .WIDTH(sof_pkg::SAMPLE_W),
        .DEPTH(sof_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .s_data(in_sample),
        .s_valid(in_valid),
        .s_ready(in_ready),
        .m_data(fifo_data),
        .m_valid(fifo_valid),
        .m_ready(load)
    );

    // ---------------------------------------------------------------
    // Bit mapper
    // ---------------------------------------------------------------
    // Mapper enable matters in bypass only; decimated data uses the field unless wide word is set
    wire [4:0] next_res = sof_pkg::res_bits(wide_word_enable, mapper_enable,
                                            decim_bypass, output_resolution_select);
    wire [19:0] next_word = sof_pkg::map_word(fifo_data, next_res);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            out_valid <= 1'b0;
            out_word <= 20'h00000;
            out_res <= sof_pkg::BITS_16;
        end
        else
        begin
            if (load)
            begin
                out_word <= next_word;
                out_res <= next_res;
            end
            if (load)
                out_valid <= 1'b1;
            else if (out_ready)
                out_valid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_wide_gives_20;
        @(posedge sys_clk) disable iff (!rst_b)
        (load && wide_word_enable) |=> (out_res == sof_pkg::BITS_20);
    endproperty
    a_wide_gives_20: assert property (p_wide_gives_20)
        else $error("wide word enable did not give 20-bit words");

    property p_bypass_unmapped_16;
        @(posedge sys_clk) disable iff (!rst_b)
        (load && decim_bypass && !mapper_enable && !wide_word_enable)
            |=> (out_res == sof_pkg::BITS_16);
    endproperty
    a_bypass_unmapped_16: assert property (p_bypass_unmapped_16)
        else $error("bypass without mapper changed the resolution");

    property p_res_14;
        @(posedge sys_clk) disable iff (!rst_b)
        (load && !wide_word_enable && !decim_bypass
            && output_resolution_select == sof_pkg::RES_14)
            |=> (out_res == sof_pkg::BITS_14) && (out_word[5:0] == 6'h00);
    endproperty
    a_res_14: assert property (p_res_14)
        else $error("code 010 did not give a 14-bit word");

    property p_res_18;
        @(posedge sys_clk) disable iff (!rst_b)
        (load && !wide_word_enable && decim_bypass && mapper_enable
            && output_resolution_select == sof_pkg::RES_18)
            |=> (out_res == sof_pkg::BITS_18);
    endproperty
    a_res_18: assert property (p_res_18)
        else $error("code 000 did not give an 18-bit word");

    property p_map_reset;
        @(posedge sys_clk) $rose(rst_b) |-> (output_mapper_config == sof_pkg::MAP_RESET);
    endproperty
    a_map_reset: assert property (p_map_reset)
        else $error("mapper register left reset with wrong value");

    property p_src_follows_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (wr_en && hit_fc) |=> (frame_clock_source_select == $past(wbyte[7]));
    endproperty
    a_src_follows_write: assert property (p_src_follows_write)
        else $error("source select did not take the written value");

    property p_reserved_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        (wr_en && hit_fc) |=> (frame_clock_config & ~sof_pkg::FC_MASK) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved frame clock bits took a value");

    property p_ready_after_setup;
        @(posedge sys_clk) disable iff (!rst_b)
        setup |=> pready ##1 !pready;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("pready not a single cycle after setup");

    property p_unmapped_err;
        @(posedge sys_clk) disable iff (!rst_b)
        (setup && !hit_any) |=> (pready && pslverr);
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped access not flagged");

    property p_out_held;
        @(posedge sys_clk) disable iff (!rst_b)
        (out_valid && !out_ready) |=> out_valid && $stable(out_word);
    endproperty
    a_out_held: assert property (p_out_held)
        else $error("output word dropped under back-pressure");

endmodule
`default_nettype wire

//--- bench/sof_rx_model.sv
// Receiving side model: takes mapped words and may stall
`timescale 1ns/1ps
`default_nettype none
module sof_rx_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Word stream from the block
    input wire logic [19:0] word,
    input wire logic [4:0] res,
    input wire logic valid,
    output logic ready,
    // Pacing from the bench
    input wire logic hold,
    input wire logic slow
);
    logic [19:0] word_q[$];
    logic [4:0] res_q[$];
    logic [7:0] pace;

    // A receiver may pause at any edge; irregular stalls probe the output hold
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ready <= 1'b0;
            pace <= 8'h5A;
        end
        else
        begin
            if (valid && ready)
            begin
                word_q.push_back(word);
                res_q.push_back(res);
            end
            pace <= {pace[6:0], pace[7] ^ pace[5] ^ pace[4] ^ pace[3]};
            ready <= !hold && (!slow || pace[0]);
        end
    end
endmodule
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the serial output frame and mapper configuration
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        n_checks++; \
        if ((got) !== (ex)) \
        begin \
            bad_count++; \
            $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
        end \
    end
module tb;
    logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic decim_bypass, core_frame_tick, ddc_frame_tick, in_valid, in_ready;
    logic [19:0] in_sample, out_word, s;
    logic [4:0] out_res;
    logic out_valid, out_ready, frame_clock, half_drive_current, err, hold, slow;
    logic [1:0] output_word_delay, bit_clock_delay;
    logic [31:0] rnd;
    logic [7:0] vs[4];
    logic [19:0] fv[16];
    int bad_count, n_checks, i, j, n;
    logic [7:0] ra[4] = '{8'h64, 8'h68, 8'h6C, 8'h78};
    logic [7:0] rv[4] = '{8'h00, 8'h00, 8'h08, 8'h00};
    logic [7:0] rm[4] = '{8'h91, 8'h40, 8'hF8, 8'h0F};

    sof_serial_out_cfg sof_serial_out_cfg_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .decim_bypass(decim_bypass),
        .core_frame_tick(core_frame_tick), .ddc_frame_tick(ddc_frame_tick),
        .in_sample(in_sample), .in_valid(in_valid), .in_ready(in_ready),
        .out_word(out_word), .out_res(out_res), .out_valid(out_valid),
        .out_ready(out_ready), .frame_clock(frame_clock),
        .half_drive_current(half_drive_current),
        .output_word_delay(output_word_delay), .bit_clock_delay(bit_clock_delay));
    sof_rx_model sof_rx_model_i (.sys_clk(sys_clk), .rst_b(rst_b), .word(out_word),
        .res(out_res), .valid(out_valid), .ready(out_ready), .hold(hold), .slow(slow));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [4:0] exp_bits(input logic byp, input logic men,
                                            input logic wide, input logic [2:0] code);
        if (wide)
            return 5'h14;
        if (byp && !men)
            return 5'h10;
        return (code == 3'h0) ? 5'h12 : ((code == 3'h2) ? 5'h0E : 5'h10);
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic give_up(input string what);
        bad_count++;
        $display("wrong value %s expected answer seen timeout", what);
        final_report();
    endtask

    // One APB transfer; the request stands until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] st);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= st;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (k = 0; k < 40; k++)
        begin
            @(posedge sys_clk);
            if (pready === 1'b1)
                break;
        end
        if (k == 40)
            give_up("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic reset_dut();
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
    endtask

    task automatic tick(input logic from_ddc);
        @(posedge sys_clk);
        core_frame_tick <= !from_ddc;
        ddc_frame_tick <= from_ddc;
        @(posedge sys_clk);
        core_frame_tick <= 1'b0;
        ddc_frame_tick <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    // Waits for the receiver to hold at least cnt words
    task automatic wait_rx(input int cnt);
        int k;
        for (k = 0; k < 400 && sof_rx_model_i.word_q.size() < cnt; k++)
            @(posedge sys_clk);
        if (k == 400)
            give_up("words at receiver");
    endtask

    task automatic send_chk(input logic [19:0] smp, input logic [4:0] b);
        int k;
        logic [4:0] got_res;
        logic [19:0] got_word;
        @(posedge sys_clk);
        in_valid <= 1'b1;
        in_sample <= smp;
        for (k = 0; k < 40; k++)
        begin
            @(posedge sys_clk);
            if (in_ready === 1'b1)
                break;
        end
        if (k == 40)
            give_up("in_ready");
        in_valid <= 1'b0;
        wait_rx(1);
        // Pop once; the compare macro names its operand twice
        got_res = sof_rx_model_i.res_q.pop_front();
        got_word = sof_rx_model_i.word_q.pop_front();
        `CHK("out_res", b, got_res)
        `CHK("out_word", smp & ~(20'hFFFFF >> b), got_word)
    endtask

    initial
    begin
        rst_b = 1'b0;
        {psel, penable, pwrite, decim_bypass, core_frame_tick, ddc_frame_tick} = '0;
        {in_valid, hold, slow} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        in_sample = 20'h0;
        rnd = 32'h4839;
        bad_count = 0;
        n_checks = 0;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        // ---------------------------------------------------------------
        // Registers: reset values, reserved bits, strobes, holes
        // ---------------------------------------------------------------
        for (i = 0; i < 4; i++)
        begin
            apb(1'b0, ra[i], 8'h00, 4'hF);
            `CHK("reset value", {24'h0, rv[i]}, rd)
            apb(1'b1, ra[i], 8'hFF, 4'hF);
            apb(1'b0, ra[i], 8'h00, 4'hF);
            `CHK("reserved bits", {24'h0, rm[i]}, rd)
            rnd = lfsr(rnd);
            vs[i] = rnd[7:0] & rm[i];
            apb(1'b1, ra[i], vs[i], 4'hF);
            apb(1'b0, ra[i], 8'h00, 4'hF);
            `CHK("readback", {24'h0, vs[i]}, rd)
        end
        `CHK("half drive", vs[1][6], half_drive_current)
        `CHK("word delay", vs[3][3:2], output_word_delay)
        `CHK("clock delay", vs[3][1:0], bit_clock_delay)
        apb(1'b1, 8'h78, ~vs[3] & 8'h0F, 4'hE);
        apb(1'b0, 8'h78, 8'h00, 4'hF);
        `CHK("strobe off write", {24'h0, vs[3]}, rd)
        apb(1'b1, 8'h70, 8'hFF, 4'hF);
        `CHK("hole write error", 1'b1, err)
        apb(1'b0, 8'h70, 8'h00, 4'hF);
        `CHK("hole read error", 1'b1, err)
        `CHK("hole read data", 32'h0, rd)
        // ---------------------------------------------------------------
        // Word width per mode; mapper enable only with bypass
        // ---------------------------------------------------------------
        apb(1'b1, 8'h64, 8'h00, 4'hF);
        for (i = 0; i < 24; i++)
        begin
            if (!i[0] && i[1])
                continue;
            decim_bypass <= i[0];
            apb(1'b1, 8'h6C, {i[1], i[2], 1'b0, i[4:3], 3'h0}, 4'hF);
            rnd = lfsr(rnd);
            send_chk(rnd[19:0], exp_bits(i[0], i[1], i[2], {1'b0, i[4:3]}));
        end
        // ---------------------------------------------------------------
        // Buffer: fill against a stalled receiver, then drain slowly
        // ---------------------------------------------------------------
        apb(1'b1, 8'h6C, 8'h48, 4'hF);
        hold <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            rnd = lfsr(rnd);
            fv[i] = rnd[19:0];
        end
        repeat (2) @(posedge sys_clk);
        n = 0;
        in_valid <= 1'b1;
        in_sample <= fv[0];
        for (i = 0; i < 20; i++)
        begin
            @(posedge sys_clk);
            if (in_ready === 1'b1)
                n++;
            in_sample <= fv[n];
        end
        in_valid <= 1'b0;
        `CHK("words taken while stalled", 9, n)
        hold <= 1'b0;
        slow <= 1'b1;
        wait_rx(9);
        for (i = 0; i < 9; i++)
        begin
            s = sof_rx_model_i.word_q.pop_front();
            `CHK("drained word", fv[i], s)
        end
        `CHK("ready when empty", 1'b1, in_ready)
        slow <= 1'b0;
        // ---------------------------------------------------------------
        // Frame clock source, divide and stretch
        // ---------------------------------------------------------------
        reset_dut();
        tick(1'b1);
        `CHK("frame clock, other source", 1'b0, frame_clock)
        tick(1'b0);
        `CHK("frame clock, core", 1'b1, frame_clock)
        // Downconverter source is only legal under complex decimation
        decim_bypass <= 1'b0;
        apb(1'b1, 8'h64, 8'h80, 4'hF);
        tick(1'b0);
        `CHK("frame clock, other source", 1'b1, frame_clock)
        tick(1'b1);
        `CHK("frame clock, downconverter", 1'b0, frame_clock)
        for (j = 0; j < 2; j++)
        begin
            reset_dut();
            // Divide goes with bypass, stretch with complex decimation
            decim_bypass <= (j == 0);
            apb(1'b1, 8'h64, (j == 0) ? 8'h10 : 8'h01, 4'hF);
            for (i = 1; i <= 4; i++)
            begin
                tick(1'b0);
                `CHK("slow frame clock", (i == 2 || i == 3), frame_clock)
            end
        end
        final_report();
    end

    initial
    begin
        repeat (100000) @(posedge sys_clk);
        give_up("whole run");
    end
endmodule
`undef CHK
`default_nettype wire
